// ==== tas_sequencer.sv ====
// acquisition sequencer: modes, trigger output and frame dropping
`timescale 1ns/1ps
module tas_sequencer #(
  parameter int SHORT_CYC = tas_pkg::TAS_PULSE_SHORT_CYC,
  parameter int LONG_CYC = tas_pkg::TAS_PULSE_LONG_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // mode selection, held steady while running
  input wire tas_pkg::tas_mode_type mode,
  // host side
  input wire logic acquire_cmd,
  output tas_pkg::tas_xfer_cmd_type xfer,
  output logic xfer_busy,
  input wire logic xfer_done,
  // external trigger input
  input wire logic trig_in,
  // sensor front end
  output tas_pkg::tas_sensor_cmd_type sensor,
  input wire logic integ_done,
  input wire logic readout_done,
  // trigger output
  output logic trig_out,
  // discard flags and their clear
  input wire logic flags_clear,
  output logic lost_early,
  output logic lost_late
);
  // the sequencer owns the capture phase and the one held frame; the
  // front end and the host link only answer with done pulses, so integration,
  // readout and transfer times live outside this block; only the continuous trig out pulse lengths are set here
  // limitation: mode may only change under reset, since a change in mid
  // frame can leave a held frame that the new mode never sends
  // capture phase codes
  typedef enum logic [1:0] {
    TAS_CAP_IDLE,
    TAS_CAP_INTEG,
    TAS_CAP_READ
  } tas_cap_type;

  typedef struct packed {
    tas_cap_type cap;               // capture phase
    logic pend;                     // finished image awaits acquire
    logic cmd;                      // acquire command outstanding
    logic xbusy;                    // transfer in progress
    logic trig_q;                   // trigger input, previous cycle
    logic [1:0] flags;              // {late lost, early lost}
    tas_pkg::tas_sensor_cmd_type sen; // sensor command pulses
    tas_pkg::tas_xfer_cmd_type xf;    // transfer pulses
    logic active;                   // acquisition plus readout phase
    logic drop;                     // finishing frame will be discarded
  } tas_state_type;

  tas_state_type st_reg, st_next;
  logic cont_pulse;
  logic trig_rise;
  logic start_ok;
  logic go;
  logic [1:0] set_flags;
  logic fresh; // a frame completed readout and is kept

  // software trigger mode
  function automatic logic is_sw(input tas_pkg::tas_mode_type m);
    return m == tas_pkg::TAS_MODE_SW;
  endfunction

  // hardware trigger mode
  function automatic logic is_hw(input tas_pkg::tas_mode_type m);
    return m == tas_pkg::TAS_MODE_HW;
  endfunction

  // free-running mode
  function automatic logic is_cont(input tas_pkg::tas_mode_type m);
    return m == tas_pkg::TAS_MODE_CONT;
  endfunction

  // continuous mode pulse source
  // it fires only in continuous mode; the triggered modes drive trig
  // out from the phase level instead
  tas_pulse_gen #(
    .SHORT_CYC(SHORT_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_pulse (
    .clk(clk),
    .rst(rst),
    .fire(st_reg.sen.start && mode == tas_pkg::TAS_MODE_CONT),
    .pulse(cont_pulse)
  );

  // trigger input edge: a held-high level counts once
  // the delayed copy resets low, the idle level of the pin, so no false
  // edge follows reset
  assign trig_rise = trig_in && !st_reg.trig_q;

  // next state: capture phase, host transfer and discard flags are
  // decided in one pass so that their precedence is explicit
  always_comb begin
    st_next = st_reg;
    // pulses last one cycle, the trigger copy follows every cycle
    st_next.trig_q = trig_in;
    st_next.sen = '0;
    st_next.xf = '0;
    set_flags = 2'h0;
    go = 1'b0;
    fresh = 1'b0;
    // capture is free only once readout ended
    start_ok = (st_reg.cap == TAS_CAP_IDLE);
    // a command is kept until a capture or a transfer spends it
    if (acquire_cmd)
      st_next.cmd = 1'b1;
    unique case (mode)
      tas_pkg::TAS_MODE_CONT: begin
        // free-running, processing overlaps next capture
        go = start_ok;
      end
      tas_pkg::TAS_MODE_SW: begin
        // command only, and never while a transfer runs
        go = start_ok && st_next.cmd && !st_reg.xbusy
          && !st_reg.pend;
      end
      tas_pkg::TAS_MODE_HW: begin
        // edge after readout ended starts capture
        go = start_ok && trig_rise;
      end
      // reserved mode code: never capture
      default: go = 1'b0;
    endcase
    // capture phases
    unique case (st_reg.cap)
      TAS_CAP_IDLE: begin
        // nothing runs; a start also raises the phase level
        if (go) begin
          st_next.cap = TAS_CAP_INTEG;
          st_next.sen.start = 1'b1;
          st_next.active = 1'b1;
          if (mode == tas_pkg::TAS_MODE_SW)
            st_next.cmd = 1'b0; // command consumed by capture
        end
      end
      TAS_CAP_INTEG: begin
        // discard decisions are taken when integration ends
        if (integ_done) begin
          st_next.cap = TAS_CAP_READ;
          if (is_hw(mode)) begin
            if (st_reg.xbusy) begin
              // link still busy: this frame can never be sent
              set_flags[1] = 1'b1;
              st_next.drop = 1'b1;
            end else if (st_reg.pend && !st_next.cmd) begin
              // nobody asked for the older frame in time
              set_flags[0] = 1'b1;
              st_next.pend = 1'b0;
            end
          end
        end
      end
      TAS_CAP_READ: begin
        // readout; the frame is handed on when it ends
        if (readout_done) begin
          st_next.cap = TAS_CAP_IDLE;
          st_next.active = 1'b0;
          st_next.sen.process = 1'b1;
          // a frame marked at integration end is never offered
          fresh = !st_reg.drop;
          st_next.drop = 1'b0;
        end
      end
      default: st_next.cap = TAS_CAP_IDLE;
    endcase
    // drop of the later image suppresses its pend at readout
    if (set_flags[1])
      st_next.flags[1] = 1'b1;
    // start transfer of the held image on an outstanding command;
    // software mode sends on its own, since capture spent the command
    if (st_reg.pend && !st_reg.xbusy
        && (is_sw(mode) || st_reg.cmd || acquire_cmd)) begin
      st_next.xbusy = 1'b1;
      st_next.xf.start = 1'b1;
      st_next.pend = 1'b0;
      // the command is spent on this transfer
      if (!is_sw(mode))
        st_next.cmd = 1'b0;
    end
    // a frame finished this cycle is held after the transfer decision
    // above, so sending the older frame cannot also discard it
    if (fresh)
      st_next.pend = 1'b1;
    // command completes when the image has been delivered
    // a done with no transfer running is ignored
    if (st_reg.xbusy && xfer_done) begin
      st_next.xbusy = 1'b0;
      st_next.xf.done = 1'b1;
    end
    // sticky flags: set wins over clear
    // a clear only removes flags that are not set again this cycle
    if (flags_clear)
      st_next.flags = 2'h0;
    st_next.flags = st_next.flags | set_flags;
  end

  // state register
  // reset leaves no frame held, no command and no transfer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{cap: TAS_CAP_IDLE, flags: tas_pkg::TAS_FLAGS_RST,
                 default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  // pulses and levels come straight from the state register; trig out in continuous mode comes from the pulse generator
  assign sensor = st_reg.sen;
  assign xfer = st_reg.xf;
  assign xfer_busy = st_reg.xbusy;
  assign lost_early = st_reg.flags[0];
  assign lost_late = st_reg.flags[1];
  // continuous mode emits timed pulses, triggered modes the phase;
  // mode selects the source, which is why it must stay steady
  assign trig_out = is_cont(mode) ? cont_pulse
                    : st_reg.active;
endmodule

// ==== tas_pkg.sv ====
// package for the triggered acquisition sequencer
// What this block does
// - software mode waits for acquire command
// - acquire completes only after image transfer ends
// - software mode: no new acquisition before transfer finishes
// - triggered modes: trigger out high during acquisition and readout
// - hardware mode starts on external trigger pulse
// - hardware mode acquire command starts image transfer
// - new trigger accepted only after readout ends
// - no acquire by next integration drops earlier image
// - transfer busy at integration end drops later
// - continuous mode captures back to back
// - continuous pulse 1 ms, every fourth 1.5 ms
// - triggered mode captures nothing without a trigger
package tas_pkg;
  // operating modes
  typedef enum logic [1:0] {
    TAS_MODE_CONT,
    TAS_MODE_SW,
    TAS_MODE_HW
  } tas_mode_type;

  // trigger output pulse lengths in continuous mode
  localparam int TAS_CLK_MHZ = 100;
  localparam int TAS_PULSE_SHORT_US = 1000;
  localparam int TAS_PULSE_LONG_US = 1500;
  localparam int TAS_PULSE_SHORT_CYC = TAS_PULSE_SHORT_US * TAS_CLK_MHZ;
  localparam int TAS_PULSE_LONG_CYC = TAS_PULSE_LONG_US * TAS_CLK_MHZ;
  localparam int TAS_LONG_EVERY = 4;
  localparam int TAS_CNT_W = 18;

  // reset value of the discard flags
  localparam logic [1:0] TAS_FLAGS_RST = 2'h0;

  // sensor control bundle toward the capture front end
  typedef struct packed {
    logic start;    // one-cycle pulse: begin acquisition
    logic process;  // one-cycle pulse: process held image
  } tas_sensor_cmd_type;

  // transfer control bundle toward the host link
  typedef struct packed {
    logic start;    // one-cycle pulse: begin sending image
    logic done;     // one-cycle pulse: acquire command completes
  } tas_xfer_cmd_type;
endpackage

// ==== tas_pulse_gen.sv ====
// trigger output pulse generator for continuous mode
`timescale 1ns/1ps
module tas_pulse_gen #(
  parameter int SHORT_CYC = tas_pkg::TAS_PULSE_SHORT_CYC,
  parameter int LONG_CYC = tas_pkg::TAS_PULSE_LONG_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic fire,
  // pulse
  output logic pulse
);
  typedef struct packed {
    logic [tas_pkg::TAS_CNT_W-1:0] cnt; // cycles left in pulse
    logic [1:0] idx;                    // pulse number modulo four
  } tas_pg_state_type;

  tas_pg_state_type st_reg, st_next;

  // both lengths must fit the counter and last at least one cycle
  if (LONG_CYC < 1 || SHORT_CYC < 1
      || LONG_CYC >= (1 << tas_pkg::TAS_CNT_W)
      || SHORT_CYC >= (1 << tas_pkg::TAS_CNT_W)) begin : g_bad_len
    $error("tas_pulse_gen: pulse length out of range");
  end

  // load a new length at each acquisition start
  always_comb begin
    st_next = st_reg;
    if (fire) begin
      // every fourth pulse is the long one
      if (st_reg.idx == 2'(tas_pkg::TAS_LONG_EVERY - 1))
        st_next.cnt = tas_pkg::TAS_CNT_W'(LONG_CYC);
      else
        st_next.cnt = tas_pkg::TAS_CNT_W'(SHORT_CYC);
      st_next.idx = st_reg.idx + 2'h1;
    end else if (st_reg.cnt != '0) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pulse = (st_reg.cnt != '0);
endmodule

// ==== tas_props.sv ====
// port assertions for the acquisition sequencer
`timescale 1ns/1ps
module tas_props #(
  parameter int SHORT_CYC = 10,
  parameter int LONG_CYC = 15
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // inputs seen by the sequencer
  input wire tas_pkg::tas_mode_type mode,
  input wire logic acquire_cmd,
  input wire logic xfer_done,
  input wire logic trig_in,
  input wire logic integ_done,
  input wire logic readout_done,
  input wire logic flags_clear,
  // outputs of the sequencer
  input wire tas_pkg::tas_xfer_cmd_type xfer,
  input wire logic xfer_busy,
  input wire tas_pkg::tas_sensor_cmd_type sensor,
  input wire logic trig_out,
  input wire logic lost_early,
  input wire logic lost_late
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // triggered modes share the trigger out timing
  wire trg = mode != tas_pkg::TAS_MODE_CONT;
  wire sw = mode == tas_pkg::TAS_MODE_SW;
  start_trig_a: assert property (
    trg && sensor.start |-> trig_out) else $error("trig out low at start");
  trig_fall_a: assert property (
    trg && trig_out && readout_done |=> !trig_out && sensor.process)
    else $error("trig out not ended after readout");
  done_after_a: assert property (
    xfer_done && xfer_busy |=> xfer.done && !xfer_busy)
    else $error("acquire not completed");
  sw_xfer_a: assert property (
    sw && sensor.process |=> xfer.start && xfer_busy)
    else $error("transfer not started");
  hw_start_a: assert property (
    mode == tas_pkg::TAS_MODE_HW && $rose(trig_in) && !trig_out &&
    !sensor.start |=> sensor.start) else $error("trigger not taken");
  busy_start_a: assert property (
    trg && $past(trig_out) && trig_out |-> !sensor.start)
    else $error("start during capture");
  sw_busy_a: assert property (
    sw && xfer_busy |-> !sensor.start) else $error("start during transfer");
  flag_hold_a: assert property (
    lost_early && !flags_clear |=> lost_early) else $error("flag dropped");
  late_drop_a: assert property (
    mode == tas_pkg::TAS_MODE_HW && trig_out && integ_done && xfer_busy
    |=> lost_late) else $error("later image not dropped");
  cover property (lost_early);
  cover property (lost_late);
  cover property (xfer.done);
endmodule

// ==== tas_partner.sv ====
// sensor front end and host link model
`timescale 1ns/1ps
module tas_partner (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // commands and latencies
  input wire tas_pkg::tas_sensor_cmd_type sensor,
  input wire tas_pkg::tas_xfer_cmd_type xfer,
  input wire logic [31:0] lat,
  input wire logic [31:0] xlat,
  // answers
  output logic integ_done,
  output logic readout_done,
  output logic xfer_done
);
  int ic, rc, xc; // countdowns, zero when idle
  // integration, then readout, each lat cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {integ_done, readout_done, xfer_done} <= 3'h0;
      {ic, rc, xc} <= '0;
    end else begin
      integ_done <= ic == 1;
      readout_done <= rc == 1;
      xfer_done <= xc == 1;
      ic <= sensor.start ? lat : (ic > 0 ? ic - 1 : 0);
      rc <= ic == 1 ? lat : (rc > 0 ? rc - 1 : 0);
      xc <= xfer.start ? xlat : (xc > 0 ? xc - 1 : 0);
    end
  end
endmodule

// ==== tas_sequencer_bench.sv ====
// self-checking bench for the acquisition sequencer
`timescale 1ns/1ps
module tas_sequencer_bench;
  logic clk, rst, acquire_cmd, xfer_done, trig_in, integ_done;
  logic readout_done, flags_clear, xfer_busy, trig_out;
  logic lost_early, lost_late;
  tas_pkg::tas_mode_type mode;
  tas_pkg::tas_xfer_cmd_type xfer;
  tas_pkg::tas_sensor_cmd_type sensor;
  int lat, xlat, errors, comparisons, dones, w, s, t, q;
  tas_sequencer #(.SHORT_CYC(10), .LONG_CYC(15)) u_tas_sequencer (
    .clk(clk), .rst(rst), .mode(mode), .acquire_cmd(acquire_cmd),
    .xfer(xfer), .xfer_busy(xfer_busy), .xfer_done(xfer_done),
    .trig_in(trig_in), .sensor(sensor), .integ_done(integ_done),
    .readout_done(readout_done), .trig_out(trig_out),
    .flags_clear(flags_clear), .lost_early(lost_early),
    .lost_late(lost_late));
  tas_partner u_tas_partner (.clk(clk), .rst(rst), .sensor(sensor),
    .xfer(xfer), .lat(lat), .xlat(xlat), .integ_done(integ_done),
    .readout_done(readout_done), .xfer_done(xfer_done));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // completed acquires seen by the host
  always @(posedge clk) if (xfer.done === 1'b1) dones++;
  task chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task wrap_up;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // restart in a mode, reset held two cycles
  task start(input tas_pkg::tas_mode_type m);
    mode <= m;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  // one-cycle pulse on trigger or acquire
  task pulse(input bit trig);
    if (trig) trig_in <= 1'b1;
    else acquire_cmd <= 1'b1;
    @(posedge clk);
    trig_in <= 1'b0;
    acquire_cmd <= 1'b0;
  endtask
  // wait for trig out low, and transfer idle if b, over three samples so
  // that the one-cycle gap between readout end and transfer start is
  // not taken for the end of the frame
  task idle(input bit b);
    s = 0;
    q = 0;
    while (q < 3 && s < 300) begin
      @(posedge clk);
      s++;
      if ((trig_out | (b & xfer_busy)) === 1'b0) q++;
      else q = 0;
    end
    chk(s < 300, "never went idle");
  endtask
  initial begin
    {rst, acquire_cmd, trig_in, flags_clear} = 4'hF;
    {acquire_cmd, trig_in, flags_clear} = 3'h0;
    mode = tas_pkg::TAS_MODE_SW;
    {lat, xlat, errors, comparisons, dones} = '0;
    w = $urandom(32'h0E80);
    start(tas_pkg::TAS_MODE_SW);
    repeat (20) @(posedge clk);
    chk(trig_out === 1'b0, "capture without command");
    for (int i = 0; i < 4; i++) begin
      lat <= 1 + $urandom % 8;
      xlat <= 1 + $urandom % 20;
      pulse(0);
      idle(1);
      chk(dones == i + 1, "image not delivered");
    end
    $display("software trigger test done");
    lat <= 6;
    xlat <= 4;
    start(tas_pkg::TAS_MODE_HW);
    repeat (20) @(posedge clk);
    chk(trig_out === 1'b0, "capture without trigger");
    pulse(1);
    @(posedge clk);
    #1 chk(trig_out === 1'b1, "trigger not taken");
    pulse(1); // ignored, capture still running
    idle(1);
    pulse(0);
    idle(1);
    chk(dones == 5, "hw image not delivered");
    pulse(1);
    idle(1);
    pulse(1);
    idle(1);
    chk(lost_early === 1'b1, "earlier image kept");
    flags_clear <= 1'b1;
    @(posedge clk);
    flags_clear <= 1'b0;
    @(posedge clk);
    #1 chk(lost_early === 1'b0, "flag not cleared");
    $display("hardware trigger test done");
    xlat <= 60;
    start(tas_pkg::TAS_MODE_HW);
    pulse(1);
    idle(0);
    pulse(0);
    repeat (1 + $urandom % 8) @(posedge clk);
    pulse(1);
    idle(1);
    chk(lost_late === 1'b1, "later image kept");
    pulse(0);
    repeat (3) @(posedge clk);
    chk(xfer_busy === 1'b0, "later image sent");
    $display("overlap test done");
    lat <= 12;
    start(tas_pkg::TAS_MODE_CONT);
    t = 0;
    for (int i = 0; i < 4; i++) begin
      for (w = 0; trig_out !== 1'b1 && w < 200; w++) @(posedge clk);
      for (w = 0; trig_out === 1'b1 && w < 200; w++) @(posedge clk);
      t += w;
    end
    chk(t == 45, "pulse lengths");
    $display("continuous test done");
    wrap_up();
  end
  // watchdog on a hang
  initial begin
    #300000;
    errors++;
    wrap_up();
  end
endmodule
bind tas_sequencer tas_props #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC))
  u_tas_props (.clk(clk), .rst(rst), .mode(mode),
  .acquire_cmd(acquire_cmd), .xfer_done(xfer_done), .trig_in(trig_in),
  .integ_done(integ_done), .readout_done(readout_done),
  .flags_clear(flags_clear), .xfer(xfer), .xfer_busy(xfer_busy),
  .sensor(sensor), .trig_out(trig_out), .lost_early(lost_early),
  .lost_late(lost_late));
